/* src/pfs_sequencer.sv */
// Power-down sequencing, bus initialize and line-clock event request.
//
// Functional notes
// [RULE1] Supply drops ac good on low line.
// [RULE2] Power-down sequence always completes once started; a dc good drop during the reset wait ends it early.
// [RULE3] Pending mastership requests hold until initialize.
// [RULE4] Initialize pulse 8-20 us after 3 ms.
// [RULE5] Halt directly after power-down initialize.
// [RULE6] Supply keeps dc good 4 ms.
// [RULE7] Initialize no sooner than 1 us after dc.
// [RULE8] Supply holds dc low at least 3 ms.
// [RULE9] Line-clock event requests interrupt, vector 100 octal.
// [RULE10] No vector-read transaction for line-clock event.
// [RULE11] Ac good drop while running starts trap.
// [RULE12] Initialize held at power-up until dc good.
// [RULE13] Power inputs synchronised before use.
//
// State walk: power-up holds initialize until dc good is seen, then runs.
// A fall of ac good while running raises one trap pulse and starts the
// reset wait; when the wait runs out, initialize is driven for the pulse
// time and the block then halts. A fall of dc good while running, waiting
// or halted waits the dc delay, drives initialize and returns to the
// power-up hold. Every count is in cycles of clk_sys.
// Ac good that never rose since power-up is not a drop, so a supply that
// brings ac good up late does not trap the freshly started processor.
`timescale 1ns/1ps
`include "pfs_consts.svh"

module pfs_sequencer #(
	parameter int RESET_WAIT_CYC = `PFS_RESET_WAIT_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ac_power_good,
	input wire logic dc_power_good,
	input wire logic line_clock_event_n,
	input wire logic event_ack,
	output logic bus_initialize_n_out,
	output logic bus_initialize_n_oe,
	output logic power_fail_trap,
	output logic halt_request,
	output logic run_indicator,
	output pfs_pkg::pfs_irq_t event_irq
);
	// ==========================================================
	// Elaboration checks
	localparam int CYC_PER_US = `PFS_CLK_HZ / 1000000;
	localparam int PULSE_MIN = `PFS_INIT_MIN_US * CYC_PER_US;
	localparam int PULSE_MAX = `PFS_INIT_MAX_US * CYC_PER_US;

	// The counter is sixteen bits wide, so longer waits cannot be served.
	if (RESET_WAIT_CYC < 1 || RESET_WAIT_CYC > 65535) begin : g_bad_wait
		$error("RESET_WAIT_CYC out of range");
	end
	// The clock must be fast enough to count whole microseconds.
	if (CYC_PER_US < 1) begin : g_bad_clk
		$error("Clock too slow for microsecond timing");
	end
	// The initialize pulse must stay inside its legal width.
	if (`PFS_INIT_PULSE_CYC < PULSE_MIN ||
		`PFS_INIT_PULSE_CYC > PULSE_MAX) begin : g_bad_pulse
		$error("Initialize pulse width out of range");
	end
	// A zero dc delay would drive initialize only two cycles after dc good is seen low.
	if (`PFS_DC_DELAY_CYC < 1) begin : g_bad_dc
		$error("Dc delay too short");
	end

	localparam logic [15:0] WAIT_CYC = 16'(RESET_WAIT_CYC);
	localparam logic [15:0] PULSE_CYC = 16'(`PFS_INIT_PULSE_CYC);
	localparam logic [15:0] DC_CYC = 16'(`PFS_DC_DELAY_CYC);

	// A rise counts once the second and third stages agree; while they differ the result is prev, so with prev low a fall counts at once.
	function automatic logic agreed(input logic [2:0] s, input logic prev);
		agreed = (s[1] == s[2]) ? s[2] : prev;
	endfunction : agreed

	// True when a settled level that was high is now seen low.
	function automatic logic fell_now(input logic was, input logic level);
		fell_now = was && !level;
	endfunction : fell_now

	pfs_pkg::pfs_regs_t r;
	pfs_pkg::pfs_regs_t next_r;
	logic ac_ok;
	logic dc_ok;
	logic ev_on;
	logic ac_drop;

	// ==========================================================
	// Input conditioning
	// The ac, dc and line-clock pins each pass three flip-flops; only the last two are compared,
	// so the first stage never feeds any decision.
	assign ac_ok = agreed(r.ac_sync, 1'b0); // [RULE13]
	assign dc_ok = agreed(r.dc_sync, 1'b0); // [RULE13]
	assign ev_on = (r.ev_sync[1] == r.ev_sync[2]) && !r.ev_sync[2];
	assign ac_drop = fell_now(r.ac_was_good, ac_ok); // [RULE11]

	// ==========================================================
	// Sequencer
	always_comb begin
		next_r = r;
		next_r.ac_sync = {r.ac_sync[1:0], ac_power_good}; // [RULE13]
		next_r.dc_sync = {r.dc_sync[1:0], dc_power_good}; // [RULE13]
		next_r.ev_sync = {r.ev_sync[1:0], line_clock_event_n}; // [RULE13]
		next_r.ac_was_good = ac_ok;
		// The count runs down to zero and rests there.
		next_r.trap = 1'b0;
		if (r.count != 16'h0000) begin
			next_r.count = r.count - 16'h0001;
		end
		// Set wins over acknowledge.
		if (ev_on && r.run) begin
			next_r.ev_pend = 1'b1; // [RULE9]
		end else if (event_ack) begin
			next_r.ev_pend = 1'b0;
		end
		case (r.state)
			// Initialize is held until dc good has settled high.
			pfs_pkg::PFS_POWERUP: begin
				next_r.bus_init = 1'b1; // [RULE12]
				next_r.run = 1'b0;
				next_r.halt = 1'b0;
				if (dc_ok) begin
					next_r.bus_init = 1'b0; // [RULE12]
					next_r.state = pfs_pkg::PFS_RUN;
					next_r.run = 1'b1;
				end
			end
			// A dc drop outranks an ac drop, since power is then lost.
			pfs_pkg::PFS_RUN: begin
				if (!dc_ok) begin
					next_r.count = DC_CYC;
					next_r.state = pfs_pkg::PFS_DCLOW;
				end else if (ac_drop) begin
					next_r.trap = 1'b1; // [RULE11]
					next_r.count = WAIT_CYC; // [RULE4]
					next_r.state = pfs_pkg::PFS_WAIT;
				end
			end
			// The reset wait runs to its end once it has started, unless dc good drops.
			pfs_pkg::PFS_WAIT: begin
				// Return of ac good is ignored here. [RULE2]
				if (!dc_ok) begin
					next_r.count = DC_CYC;
					next_r.state = pfs_pkg::PFS_DCLOW;
				end else if (r.count == 16'h0000) begin
					next_r.bus_init = 1'b1; // [RULE4]
					next_r.count = PULSE_CYC;
					next_r.state = pfs_pkg::PFS_INIT;
				end
			end
			// The pulse ends one cycle early so it lasts exactly its count.
			pfs_pkg::PFS_INIT: begin
				if (r.count == 16'h0001) begin
					next_r.bus_init = 1'b0; // [RULE4]
					next_r.halt = 1'b1; // [RULE5]
					next_r.run = 1'b0; // [RULE5]
					next_r.state = pfs_pkg::PFS_HALT;
				end
			end
			// Halted until the supply finally drops dc good.
			pfs_pkg::PFS_HALT: begin
				if (!dc_ok) begin
					next_r.count = DC_CYC;
					next_r.state = pfs_pkg::PFS_DCLOW;
				end
			end
			// Wait the dc delay, then drive initialize for power-up.
			pfs_pkg::PFS_DCLOW: begin
				next_r.run = 1'b0;
				next_r.halt = 1'b1;
				if (r.count == 16'h0000) begin
					next_r.bus_init = 1'b1; // [RULE7]
					next_r.halt = 1'b0;
					next_r.state = pfs_pkg::PFS_POWERUP;
				end
			end
			default: begin
				next_r.state = pfs_pkg::PFS_POWERUP;
			end
		endcase
	end

	// Reset puts the block in the power-up hold with initialize driven.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r.state <= pfs_pkg::PFS_POWERUP;
			r.ac_sync <= 3'h0;
			r.dc_sync <= 3'h0;
			r.ev_sync <= 3'h7;
			r.count <= 16'h0000;
			r.bus_init <= 1'b1;
			r.trap <= 1'b0;
			r.halt <= 1'b0;
			r.run <= 1'b0;
			r.ev_pend <= 1'b0;
			r.ac_was_good <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	// The initialize line is open drain: the data is always low and
	// the enable alone decides whether the line is pulled down.
	assign bus_initialize_n_out = 1'b0;
	assign bus_initialize_n_oe = r.bus_init;
	assign power_fail_trap = r.trap;
	assign halt_request = r.halt;
	assign run_indicator = r.run;
	assign event_irq.req = r.ev_pend; // [RULE9]
	assign event_irq.vector = `PFS_EVENT_VECTOR; // [RULE9]
	assign event_irq.vector_read = 1'b0; // [RULE10]
endmodule : pfs_sequencer

/* include/pfs_consts.svh */
// Timing constants and codes for the power-fail sequencer.
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
`define PFS_CLK_HZ 10000000
`define PFS_RESET_WAIT_US 3000
`define PFS_RESET_WAIT_CYC ((`PFS_RESET_WAIT_US * (`PFS_CLK_HZ / 1000000)))
`define PFS_INIT_MIN_US 8
`define PFS_INIT_MAX_US 20
`define PFS_INIT_PULSE_US 10
`define PFS_INIT_PULSE_CYC ((`PFS_INIT_PULSE_US * (`PFS_CLK_HZ / 1000000)))
`define PFS_DC_DELAY_US 1
`define PFS_DC_DELAY_CYC ((`PFS_DC_DELAY_US * (`PFS_CLK_HZ / 1000000)))
`define PFS_EVENT_VECTOR 9'h040
`endif

/* include/pfs_pkg.sv */
// Types shared by the power-fail sequencer.
package pfs_pkg;
	typedef enum logic [5:0] {
		PFS_POWERUP = 6'h01,
		PFS_RUN = 6'h02,
		PFS_WAIT = 6'h04,
		PFS_INIT = 6'h08,
		PFS_HALT = 6'h10,
		PFS_DCLOW = 6'h20
	} pfs_state_t;

	typedef struct packed {
		logic req;
		logic [8:0] vector;
		logic vector_read;
	} pfs_irq_t;

	typedef struct packed {
		pfs_state_t state;
		logic [2:0] ac_sync;
		logic [2:0] dc_sync;
		logic [2:0] ev_sync;
		logic [15:0] count;
		logic bus_init;
		logic trap;
		logic halt;
		logic run;
		logic ev_pend;
		logic ac_was_good;
	} pfs_regs_t;
endpackage : pfs_pkg

/* tb/pfs_props.sv */
// Port checks on the power-fail sequencer.
`timescale 1ns/1ps
module pfs_props #(parameter int RESET_WAIT_CYC = 50) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ac_power_good,
	input wire logic dc_power_good,
	input wire logic line_clock_event_n,
	input wire logic bus_initialize_n_oe,
	input wire logic power_fail_trap,
	input wire logic halt_request,
	input wire logic run_indicator,
	input wire pfs_pkg::pfs_irq_t event_irq
);
	localparam int LO = RESET_WAIT_CYC;
	localparam int HI = RESET_WAIT_CYC + 9;
	int hi;
	int since;
	always_ff @(posedge clk_sys) begin
		hi <= bus_initialize_n_oe ? hi + 1 : 0;
		since <= power_fail_trap ? 0 : since + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_TRAP: assert property (run_indicator && $fell(ac_power_good)
		|-> ##[2:6] power_fail_trap) else $error("no trap");
	AST_DONE: assert property (power_fail_trap
		|-> ##[LO:HI] bus_initialize_n_oe) else $error("no init");
	AST_WAIT: assert property ($rose(bus_initialize_n_oe) && run_indicator
		|-> since >= LO) else $error("init early");
	AST_WIDTH: assert property ($rose(halt_request) && $fell(bus_initialize_n_oe)
		|-> hi inside {[80:200]}) else $error("bad init width");
	AST_HALT: assert property ($fell(bus_initialize_n_oe) && $past(run_indicator)
		|-> halt_request && !run_indicator) else $error("no halt");
	AST_DC: assert property ($fell(dc_power_good)
		|-> !$rose(bus_initialize_n_oe) [*8] ##1
		!$rose(bus_initialize_n_oe) [*2] ##[1:40] bus_initialize_n_oe)
		else $error("dc init timing");
	AST_VEC: assert property (event_irq.req
		|-> event_irq.vector == 9'h040 && !event_irq.vector_read)
		else $error("bad vector");
	AST_EVT: assert property ((run_indicator && !line_clock_event_n) [*5]
		|-> event_irq.req) else $error("event lost");
endmodule : pfs_props

/* tb/pfs_supply.sv */
// Behavioural power supply driving the two power-status lines.
`timescale 1ns/1ps
module pfs_supply (
	input wire logic clk_sys,
	output logic ac_power_good,
	output logic dc_power_good
);
	initial {ac_power_good, dc_power_good} = 2'b00;
	task automatic up(input int settle);
		repeat (settle) @(posedge clk_sys);
		dc_power_good <= 1'b1;
		repeat (settle) @(posedge clk_sys);
		ac_power_good <= 1'b1;
	endtask : up
	task automatic down(input int hold, input logic bounce);
		@(posedge clk_sys);
		ac_power_good <= 1'b0;
		repeat (20) @(posedge clk_sys);
		ac_power_good <= bounce;
		repeat (hold) @(posedge clk_sys);
		{ac_power_good, dc_power_good} <= 2'b00;
		repeat (30) @(posedge clk_sys);
	endtask : down
endmodule : pfs_supply

/* tb/pfs_sequencer_test.sv */
// Self-checking bench for the power-fail sequencer.
`timescale 1ns/1ps
module pfs_sequencer_test;
	localparam int W = 50;
	logic clk_sys = 0, sys_rst = 1, ev_n = 1, ack = 0;
	logic ac, dc, oe, trap, halt, run;
	pfs_pkg::pfs_irq_t irq;
	int mismatches = 0, samples_checked = 0, n;
	logic [7:0] lfsr = 8'h2d;
	logic mreq = 1'b0;
	wire [3:0] obs = {dc, irq.req, trap, oe};
	always #50 clk_sys = ~clk_sys;
	// A peripheral asks for mastership at power fail and holds it.
	always @(posedge clk_sys) mreq <= oe ? 1'b0 : (trap | mreq);
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	pfs_supply sup (.clk_sys(clk_sys), .ac_power_good(ac), .dc_power_good(dc));
	pfs_sequencer #(.RESET_WAIT_CYC(W)) dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .ac_power_good(ac), .dc_power_good(dc),
		.line_clock_event_n(ev_n), .event_ack(ack), .bus_initialize_n_out(),
		.bus_initialize_n_oe(oe), .power_fail_trap(trap),
		.halt_request(halt), .run_indicator(run), .event_irq(irq));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic waitf(input int w, input logic v);
		n = 0;
		while (obs[w] !== v) begin
			@(negedge clk_sys);
			n++;
			if (n > 5000) begin
				mismatches++;
				conclude();
			end
		end
	endtask : waitf
	initial begin
		repeat (4) @(negedge clk_sys);
		check({oe, run, halt, irq.req}, 4'h8);
		@(posedge clk_sys) sys_rst <= 1'b0;
		@(negedge clk_sys);
		check(oe, 1);
		sup.up(30);
		waitf(0, 0);
		check(run, 1);
		@(posedge clk_sys) ev_n <= 1'b0;
		waitf(2, 1);
		check({irq.vector, irq.vector_read}, {9'h040, 1'b0});
		@(posedge clk_sys) ev_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		ack <= 1'b1;
		@(posedge clk_sys) ack <= 1'b0;
		@(negedge clk_sys) check(irq.req, 0);
		lfsr = lfsr_next(lfsr);
		fork
			sup.down(300 + lfsr, 1'b1);
		join_none
		waitf(1, 1);
		waitf(0, 1);
		check(n, W + 1);
		check(mreq, 1);
		waitf(0, 0);
		check(n, 100);
		check(mreq, 0);
		check({halt, run}, 2'b10);
		waitf(3, 0);
		waitf(0, 1);
		check(n >= 10 && n <= 20, 1);
		wait fork;
		sup.up(30);
		waitf(0, 0);
		check({dc, halt}, 2'b10);
		conclude();
	end
endmodule : pfs_sequencer_test
bind pfs_sequencer pfs_props #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .ac_power_good(ac_power_good),
	.dc_power_good(dc_power_good), .line_clock_event_n(line_clock_event_n),
	.bus_initialize_n_oe(bus_initialize_n_oe),
	.power_fail_trap(power_fail_trap), .halt_request(halt_request),
	.run_indicator(run_indicator), .event_irq(event_irq));
